// ### design/gpio_port_config.sv
// gpio port block: two 8-bit ports, one 2-bit port, apb register access
// assumes pads resolve the drive controls; pad inputs are asynchronous
module gpio_port_config #(
    parameter int p_width = gpio_pkg::wide_port_width,
    parameter int n_width = gpio_pkg::narrow_port_width
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          fast_ext_clock,
    output logic                               reset_pin_is_reset,
    input  wire logic [p_width-1:0]            port0_pad_in,
    input  wire logic [p_width-1:0]            port1_pad_in,
    input  wire logic [n_width-1:0]            port3_pad_in,
    output gpio_pkg::pad_drive_s [p_width-1:0] port0_drive,
    output gpio_pkg::pad_drive_s [p_width-1:0] port1_drive,
    output gpio_pkg::pad_drive_s [n_width-1:0] port3_drive
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]         p0_ma_r;
    logic [7:0]         p0_mb_r;
    logic [7:0]         p1_ma_r;
    logic [7:0]         p1_mb_r;
    logic [3:0]         p3_mode_r;
    logic [7:0]         p0_dis_r;
    logic [p_width-1:0] p0_latch_r;
    logic [p_width-1:0] p1_latch_r;
    logic [n_width-1:0] p3_latch_r;
    logic [p_width-1:0] p0_level;
    logic [p_width-1:0] p1_level;
    logic [n_width-1:0] p3_level;
    logic               wr_en;
    logic               addr_ok;
    logic [31:0]        rd_nxt;
    logic [31:0]        prdata_r;

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign pslverr = psel && penable && !addr_ok;

    function automatic logic known_addr(input logic [7:0] a);
        return a == gpio_pkg::port0_mode_select_a_off
            || a == gpio_pkg::port0_mode_select_b_off
            || a == gpio_pkg::port1_mode_select_a_off
            || a == gpio_pkg::port1_mode_select_b_off
            || a == gpio_pkg::port0_digital_input_disable_off
            || a == gpio_pkg::port0_latch_off
            || a == gpio_pkg::port1_latch_off
            || a == gpio_pkg::port3_latch_off
            || a == gpio_pkg::port0_level_off
            || a == gpio_pkg::port1_level_off
            || a == gpio_pkg::port3_level_off
            || a == gpio_pkg::port3_mode_off;
    endfunction

    assign addr_ok = known_addr(paddr);

    // ****************************************
    // mode registers
    // ****************************************
    // all pins come out of reset input-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_ma_r   <= gpio_pkg::mode_a_reset;
            p0_mb_r   <= gpio_pkg::mode_b_reset;
            p1_ma_r   <= gpio_pkg::mode_a_reset;
            p1_mb_r   <= gpio_pkg::mode_b_reset;
            p3_mode_r <= gpio_pkg::narrow_mode_reset;
        end else if (wr_en) begin
            if (paddr == gpio_pkg::port0_mode_select_a_off) p0_ma_r <= pwdata[7:0];
            if (paddr == gpio_pkg::port0_mode_select_b_off) p0_mb_r <= pwdata[7:0];
            if (paddr == gpio_pkg::port1_mode_select_a_off) p1_ma_r <= pwdata[7:0];
            if (paddr == gpio_pkg::port1_mode_select_b_off) p1_mb_r <= pwdata[7:0];
            if (paddr == gpio_pkg::port3_mode_off) p3_mode_r <= pwdata[3:0];
        end
    end

    // digital input disable, only bits 1..5 exist
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_dis_r <= gpio_pkg::dis_reset;
        end else if (wr_en && paddr == gpio_pkg::port0_digital_input_disable_off) begin
            p0_dis_r <= pwdata[7:0] & gpio_pkg::dis_field_mask;
        end
    end

    // port latches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_latch_r <= p_width'(gpio_pkg::latch_reset);
            p1_latch_r <= p_width'(gpio_pkg::latch_reset);
            p3_latch_r <= n_width'(gpio_pkg::latch_reset);
        end else if (wr_en) begin
            if (paddr == gpio_pkg::port0_latch_off) p0_latch_r <= pwdata[p_width-1:0];
            if (paddr == gpio_pkg::port1_latch_off) p1_latch_r <= pwdata[p_width-1:0];
            if (paddr == gpio_pkg::port3_latch_off) p3_latch_r <= pwdata[n_width-1:0];
        end
    end

    // the reset duty takes the shared pin whenever a fast external clock runs
    assign reset_pin_is_reset = fast_ext_clock;

    // ****************************************
    // per-pin filter and drive
    // ****************************************
    for (genvar i = 0; i < p_width; i++) begin : g_wide
        pin_filter u_f0 (.pclk(pclk), .presetn(presetn),
                         .pad_in(port0_pad_in[i]), .level(p0_level[i]));
        pin_filter u_f1 (.pclk(pclk), .presetn(presetn),
                         .pad_in(port1_pad_in[i]), .level(p1_level[i]));
        pin_drive u_d0 (.pclk(pclk), .presetn(presetn),
                        .mode({p0_ma_r[i], p0_mb_r[i]}), .latch(p0_latch_r[i]),
                        .level(p0_level[i]), .input_only(1'b0),
                        .drive(port0_drive[i]));
        // the reset-shared pin never drives
        pin_drive u_d1 (.pclk(pclk), .presetn(presetn),
                        .mode({p1_ma_r[i], p1_mb_r[i]}), .latch(p1_latch_r[i]),
                        .level(p1_level[i]),
                        .input_only(i == gpio_pkg::reset_pin_index),
                        .drive(port1_drive[i]));
    end

    for (genvar j = 0; j < n_width; j++) begin : g_narrow
        pin_filter u_f3 (.pclk(pclk), .presetn(presetn),
                         .pad_in(port3_pad_in[j]), .level(p3_level[j]));
        pin_drive u_d3 (.pclk(pclk), .presetn(presetn),
                        .mode(p3_mode_r[2*j +: 2]), .latch(p3_latch_r[j]),
                        .level(p3_level[j]), .input_only(1'b0),
                        .drive(port3_drive[j]));
    end

    // ****************************************
    // read mux
    // ****************************************
    // level reads return filtered pins; disabled port 0 inputs read zero
    always_comb begin
        rd_nxt = 32'h0;
        unique case (paddr)
            gpio_pkg::port0_mode_select_a_off:         rd_nxt[7:0] = p0_ma_r;
            gpio_pkg::port0_mode_select_b_off:         rd_nxt[7:0] = p0_mb_r;
            gpio_pkg::port1_mode_select_a_off:         rd_nxt[7:0] = p1_ma_r;
            gpio_pkg::port1_mode_select_b_off:         rd_nxt[7:0] = p1_mb_r;
            gpio_pkg::port3_mode_off:                  rd_nxt[3:0] = p3_mode_r;
            gpio_pkg::port0_digital_input_disable_off: rd_nxt[7:0] = p0_dis_r;
            gpio_pkg::port0_latch_off: rd_nxt[p_width-1:0] = p0_latch_r;
            gpio_pkg::port1_latch_off: rd_nxt[p_width-1:0] = p1_latch_r;
            gpio_pkg::port3_latch_off: rd_nxt[n_width-1:0] = p3_latch_r;
            gpio_pkg::port0_level_off:
                rd_nxt[p_width-1:0] = p0_level & ~p0_dis_r[p_width-1:0];
            gpio_pkg::port1_level_off: rd_nxt[p_width-1:0] = p1_level;
            gpio_pkg::port3_level_off: rd_nxt[n_width-1:0] = p3_level;
            default:                   rd_nxt = 32'h0;
        endcase
    end

    // read data taken in the setup cycle so it stands from a flop in the access cycle;
    // a level read therefore shows the pin as filtered one clock before the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata = prdata_r;

endmodule // gpio_port_config

// ### design/gpio_pkg.sv
// package for the gpio port block: register map, field positions, reset values
// assumes an apb slave with 32-bit data and word-aligned registers
package gpio_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] port0_mode_select_a_off         = 8'h00;
    localparam logic [7:0] port0_mode_select_b_off         = 8'h04;
    localparam logic [7:0] port1_mode_select_a_off         = 8'h08;
    localparam logic [7:0] port1_mode_select_b_off         = 8'h0c;
    localparam logic [7:0] port0_digital_input_disable_off = 8'h10;
    localparam logic [7:0] port0_latch_off                 = 8'h14;
    localparam logic [7:0] port1_latch_off                 = 8'h18;
    localparam logic [7:0] port3_latch_off                 = 8'h1c;
    localparam logic [7:0] port0_level_off                 = 8'h20;
    localparam logic [7:0] port1_level_off                 = 8'h24;
    localparam logic [7:0] port3_level_off                 = 8'h28;
    localparam logic [7:0] port3_mode_off                  = 8'h2c;

    // ****************************************
    // widths, fields and reset values
    // ****************************************
    localparam int         wide_port_width   = 8;
    localparam int         narrow_port_width = 2;
    localparam int         reset_pin_index   = 5;     // port 1 pin shared with reset
    localparam logic [7:0] mode_a_reset      = 8'hff; // input-only after power-up
    localparam logic [7:0] mode_b_reset      = 8'h00;
    localparam logic [3:0] narrow_mode_reset = 4'ha;  // port 3: both pins input-only
    localparam logic [7:0] latch_reset       = 8'hff;
    localparam logic [7:0] dis_field_mask    = 8'h3e; // bits 1..5 only
    localparam logic [7:0] dis_reset         = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int strong_pullup_clocks = 2;  // cpu clocks of strong pull-up
    localparam int glitch_filter_clocks = 2;  // stable clocks before a level counts

    // drive mode, bits {mode_select_a_bit, mode_select_b_bit}
    typedef enum logic [1:0] {
        mode_quasi  = 2'h0,
        mode_push   = 2'h1,
        mode_input  = 2'h2,
        mode_open   = 2'h3
    } drive_mode_e;

    // drive controls of one pin toward the pad
    typedef struct packed {
        logic pull_down;
        logic strong_up;
        logic weak_up;
        logic very_weak_up;
    } pad_drive_s;

endpackage : gpio_pkg

// ### design/pin_filter.sv
// glitch suppression for one pad input
// assumes the pad is asynchronous to pclk
module pin_filter #(
    parameter int stable_clocks = gpio_pkg::glitch_filter_clocks
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pad_in,
    output logic      level
);

    logic [2:0] sync_r;
    logic [3:0] count_r;

    // three-stage synchroniser; second and third must agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= {sync_r[1:0], pad_in};
        end
    end

    // a new level must hold stable_clocks agreeing samples before it is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 4'h0;
            level   <= 1'b0;
        end else if (sync_r[2] != sync_r[1] || sync_r[1] == level) begin
            count_r <= 4'h0;
        end else if (count_r >= 4'(stable_clocks - 1)) begin
            count_r <= 4'h0;
            level   <= sync_r[1];
        end else begin
            count_r <= count_r + 4'h1;
        end
    end

endmodule // pin_filter

// ### design/pin_drive.sv
// drive decode for one port pin: mode, latch and sensed level to pad controls
// assumes the sensed level is already filtered and on pclk
module pin_drive (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [1:0]          mode,
    input  wire logic                latch,
    input  wire logic                level,
    input  wire logic                input_only,
    output gpio_pkg::pad_drive_s     drive
);

    logic       latch_d_r;
    logic [1:0] boost_r;

    // strong pull-up pulse on a latch rise, held for a fixed count of clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_d_r <= 1'b1;
            boost_r   <= 2'h0;
        end else begin
            latch_d_r <= latch;
            if (latch && !latch_d_r) begin
                boost_r <= 2'(gpio_pkg::strong_pullup_clocks);
            end else if (boost_r != 2'h0) begin
                boost_r <= boost_r - 2'h1;
            end
        end
    end

    // mode decode; the reset pin ignores its mode bits entirely
    always_comb begin
        drive = '0;
        if (!input_only) begin
            unique case (gpio_pkg::drive_mode_e'(mode))
                gpio_pkg::mode_quasi: begin
                    drive.pull_down    = !latch;
                    drive.very_weak_up = latch;
                    drive.weak_up      = latch && level;
                    drive.strong_up    = latch && boost_r != 2'h0;
                end
                gpio_pkg::mode_push: begin
                    drive.strong_up = latch;
                    drive.pull_down = !latch;
                end
                gpio_pkg::mode_input: begin
                    drive = '0;
                end
                gpio_pkg::mode_open: begin
                    drive.pull_down = !latch;
                end
            endcase
        end
    end

endmodule // pin_drive

// ### tb/pad_world.sv
// partner model: outside circuitry on one port's pads
// assumes drive controls are active high; ext_val stands in for a floating pad
module pad_world #(
    parameter int w = 8
) (
    input  wire gpio_pkg::pad_drive_s [w-1:0] drive,
    input  wire logic [w-1:0]                 ext_low,
    input  wire logic [w-1:0]                 ext_val,
    output logic      [w-1:0]                 pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // an outside sink beats any pull-up; undriven pads take the bench value
    always_comb begin
        for (int i = 0; i < w; i++) begin
            if (drive[i].pull_down || ext_low[i]) pad[i] = 1'b0;
            else if (drive[i].strong_up || drive[i].weak_up || drive[i].very_weak_up) pad[i] = 1'b1;
            else pad[i] = ext_val[i];
        end
    end
endmodule // pad_world

// ### tb/gpio_port_config_props.sv
// port-level assertions for the gpio port block
// assumes a single pclk domain and presetn asynchronous active low
module gpio_port_config_props #(
    parameter int p_width = 8,
    parameter int n_width = 2
) (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic [7:0]                    paddr,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic                          fast_ext_clock,
    input wire logic                          reset_pin_is_reset,
    input wire logic [p_width-1:0]            port0_pad_in,
    input wire gpio_pkg::pad_drive_s [p_width-1:0] port0_drive,
    input wire gpio_pkg::pad_drive_s [p_width-1:0] port1_drive
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] low_cnt_r;
    logic       q_strong;
    // run length of a low pad on port 0 pin 0, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt_r <= 4'h0;
        else if (port0_pad_in[0]) low_cnt_r <= 4'h0;
        else if (low_cnt_r != 4'hf) low_cnt_r <= low_cnt_r + 4'h1;
    end
    assign q_strong = port0_drive[0].strong_up && port0_drive[0].very_weak_up;
    property p_ready; psel && penable |-> pready; endproperty
    property p_err_phase; pslverr |-> psel && penable; endproperty
    property p_unmapped; psel && penable && paddr > 8'h2c |-> pslverr; endproperty
    property p_rst_duty; reset_pin_is_reset == fast_ext_clock; endproperty
    property p_rst_pin; port1_drive[5] == '0; endproperty
    property p_weak_off; low_cnt_r >= 4'h8 |-> !port0_drive[0].weak_up; endproperty
    property p_pulse; $rose(q_strong) |=> q_strong ##1 !q_strong; endproperty
    property p_boot; $rose(presetn) |-> port0_drive == '0 && port1_drive == '0; endproperty
    property p_excl;
        !(port0_drive[0].pull_down && (port0_drive[0].strong_up || port0_drive[0].very_weak_up));
    endproperty
    property p_vweak; port0_drive[0].weak_up |-> port0_drive[0].very_weak_up; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
    a_rst_duty: assert property (p_rst_duty) else $error("reset duty mismatch");
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin driven");
    a_weak_off: assert property (p_weak_off) else $error("weak pull-up on low pin");
    a_pulse: assert property (p_pulse) else $error("strong pulse not two clocks");
    a_boot: assert property (p_boot) else $error("drive after reset");
    a_excl: assert property (p_excl) else $error("pull-down with pull-up");
    a_vweak: assert property (p_vweak) else $error("weak without very weak");
    c_pulse: cover property ($rose(q_strong));
    c_weak: cover property (port0_drive[0].weak_up);
    c_err: cover property (pslverr);
endmodule // gpio_port_config_props
bind gpio_port_config gpio_port_config_props #(.p_width(p_width), .n_width(n_width)) props_u (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .fast_ext_clock,
    .reset_pin_is_reset, .port0_pad_in, .port0_drive, .port1_drive);

// ### tb/gpio_port_config_tb_top.sv
// self-checking bench for the gpio port block
// assumes zero-wait apb slave and pad_world models on all three ports
module gpio_port_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        fast_ext_clock, reset_pin_is_reset;
    logic [7:0]  paddr, p0_pad, p1_pad, p0_low, p1_low, p0_val, p1_val, v, dis;
    logic [31:0] pwdata, prdata, rdat, seed;
    logic [1:0]  p3_pad, p3_low, p3_val;
    gpio_pkg::pad_drive_s [7:0] p0_drv, p1_drv;
    gpio_pkg::pad_drive_s [1:0] p3_drv;
    int          err_total, checks, cnt;
    gpio_port_config dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fast_ext_clock, .reset_pin_is_reset, .port0_pad_in(p0_pad),
        .port1_pad_in(p1_pad), .port3_pad_in(p3_pad), .port0_drive(p0_drv),
        .port1_drive(p1_drv), .port3_drive(p3_drv));
    pad_world #(.w(8)) p0_u (.drive(p0_drv), .ext_low(p0_low), .ext_val(p0_val), .pad(p0_pad));
    pad_world #(.w(8)) p1_u (.drive(p1_drv), .ext_low(p1_low), .ext_val(p1_val), .pad(p1_pad));
    pad_world #(.w(2)) p3_u (.drive(p3_drv), .ext_low(p3_low), .ext_val(p3_val), .pad(p3_pad));
    task automatic summarize;
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed; only the watchdog ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected pad controls from mode, latch and pin level
    function automatic logic [31:0] exp_drv(input logic [1:0] m, input logic l, input logic lv);
        gpio_pkg::pad_drive_s d;
        d = '0;
        if (m != 2'h2) d.pull_down = !l;
        if (m == 2'h1) d.strong_up = l;
        if (m == 2'h0) d.very_weak_up = l;
        if (m == 2'h0) d.weak_up = l & lv;
        return {28'h0, d};
    endfunction
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // watchdog: the whole sequence needs well under 10k clocks
    initial begin
        #200000;
        err_total++;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, fast_ext_clock, paddr, pwdata} = '0;
        {p0_low, p1_low, p3_low, p0_val, p1_val, p3_val} = '0;
        seed = 32'h00015ef9;
        err_total = 0;
        checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gpio_pkg::port0_mode_select_a_off, 32'h0); chk(rdat, 32'hff);
        apb(1'b0, gpio_pkg::port1_mode_select_b_off, 32'h0); chk(rdat, 32'h00);
        apb(1'b0, 8'h30, 32'h0); chk({rdat[30:0], e}, 32'h1);
        // every mode with both latch values on port 0 pin 0
        for (int m = 0; m < 4; m++) begin
            for (int l = 0; l < 2; l++) begin
                apb(1'b1, gpio_pkg::port0_latch_off, {31'h0, l[0]});
                apb(1'b1, gpio_pkg::port0_mode_select_a_off, {24'h0, 7'h7f, m[1]});
                apb(1'b1, gpio_pkg::port0_mode_select_b_off, {31'h0, m[0]});
                repeat (10) @(posedge pclk);
                chk({28'h0, p0_drv[0]}, exp_drv(m[1:0], l[0], 1'b1));
            end
        end
        // quasi latch 0 -> 1 gives a two-clock strong pull-up
        apb(1'b1, gpio_pkg::port0_mode_select_a_off, 32'hfe);
        apb(1'b1, gpio_pkg::port0_mode_select_b_off, 32'h00);
        apb(1'b1, gpio_pkg::port0_latch_off, 32'h00);
        apb(1'b1, gpio_pkg::port0_latch_off, 32'h01);
        cnt = 0;
        repeat (6) @(posedge pclk) cnt += p0_drv[0].strong_up;
        chk(cnt, 2);
        p0_low <= 8'h01;
        repeat (12) @(posedge pclk);
        chk({28'h0, p0_drv[0]}, exp_drv(2'h0, 1'b1, 1'b0));
        p0_low <= 8'h00;
        // reset-shared pin stays undriven in push-pull with latch low
        apb(1'b1, gpio_pkg::port1_mode_select_a_off, 32'h00);
        apb(1'b1, gpio_pkg::port1_latch_off, 32'hdf);
        apb(1'b1, gpio_pkg::port1_mode_select_b_off, 32'h20);
        repeat (4) @(posedge pclk);
        chk({28'h0, p1_drv[5]}, 32'h0);
        for (int f = 0; f < 2; f++) begin
            fast_ext_clock <= f[0];
            repeat (2) @(posedge pclk);
            chk({31'h0, reset_pin_is_reset}, f);
        end
        // random pad levels and disable masks, port 0 input-only
        apb(1'b1, gpio_pkg::port0_mode_select_a_off, 32'hff);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr_step(seed);
            v = seed[7:0];
            dis = seed[15:8];
            p0_val <= v;
            apb(1'b1, gpio_pkg::port0_digital_input_disable_off, {24'h0, dis});
            repeat (8) @(posedge pclk);
            apb(1'b0, gpio_pkg::port0_level_off, 32'h0);
            chk(rdat, {24'h0, v & ~(dis & 8'h3e)});
            apb(1'b0, gpio_pkg::port0_digital_input_disable_off, 32'h0);
            chk(rdat, {24'h0, dis & 8'h3e});
        end
        // a mid-run reset clears the disable bits
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gpio_pkg::port0_digital_input_disable_off, 32'h0); chk(rdat, 32'h0);
        // one-clock release of a held-low quasi pin 4 must not wake its weak pull-up
        apb(1'b1, gpio_pkg::port0_mode_select_a_off, 32'hef);
        p0_val <= 8'h00;
        p0_low <= 8'h10;
        repeat (10) @(posedge pclk);
        p0_low <= 8'h00;
        @(posedge pclk);
        p0_low <= 8'h10;
        cnt = 0;
        repeat (12) @(posedge pclk) cnt += p0_drv[4].weak_up;
        chk(cnt, 0);
        apb(1'b0, gpio_pkg::port0_level_off, 32'h0); chk(rdat, 32'h0);
        p3_val <= 2'h3;
        repeat (10) @(posedge pclk);
        apb(1'b0, gpio_pkg::port3_level_off, 32'h0); chk(rdat, 32'h3);
        // port 3: pin 0 push-pull high, pin 1 quasi low
        apb(1'b1, gpio_pkg::port3_mode_off, 32'h1);
        apb(1'b1, gpio_pkg::port3_latch_off, 32'h1);
        repeat (10) @(posedge pclk);
        chk({28'h0, p3_drv[0]}, exp_drv(2'h1, 1'b1, 1'b1));
        chk({28'h0, p3_drv[1]}, exp_drv(2'h0, 1'b0, 1'b0));
        apb(1'b0, gpio_pkg::port3_level_off, 32'h0); chk(rdat, 32'h1);
        summarize();
    end
endmodule // gpio_port_config_tb_top
